// [rtl/ict_ctrl.sv]
// Digital control of an isolated CAN transceiver
// Notes on behaviour
// - A high standby select disables the bus driver; low means normal operation.
// - Low transmit data drives the bus dominant, high leaves it recessive.
// - In normal operation, transmit data low beyond the dominant timeout disables the driver and forces receive high.
// - After a timeout the driver stays off until transmit data rises.
// - Receive goes low above the upper differential threshold and high below the lower one.
// - Shorted or undriven terminated lines give a high receive output.
// - A line pulled past either fault level is set to high impedance.
// - Over-temperature floats both lines and stops all functions until the cool level is reached.
// - A driver short limits drive, and normal drive returns by itself once it clears.
`timescale 1ns/1ps
`default_nettype none
`include "ict_params.svh"

module ict_ctrl #(
    parameter int DOM_TIMEOUT_CYC = `ICT_DOM_TIMEOUT_CYC
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic txd,
    input  wire logic standby_select,
    input  wire logic temp_over_hot,
    input  wire logic temp_below_hyst,
    input  wire logic canh_fault,
    input  wire logic canl_fault,
    input  wire logic drv_short,
    input  wire logic diff_above_hi,
    input  wire logic diff_below_lo,
    output logic      rxd,
    output logic      canh_dom,
    output logic      canl_dom,
    output logic      canh_oe,
    output logic      canl_oe,
    output logic      drive_limit,
    output logic      standby_active,
    output logic      thermal_off,
    output logic      dom_fault
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [`ICT_NPINS-1:0] pins_in;
    logic [`ICT_NPINS-1:0] meta_r;
    logic [`ICT_NPINS-1:0] pin_r;

    assign pins_in = {diff_below_lo, diff_above_hi, drv_short, canl_fault, canh_fault,
                      temp_below_hyst, temp_over_hot, standby_select, txd};

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_r <= `ICT_PIN_IDLE;
            pin_r  <= `ICT_PIN_IDLE;
        end
        else
        begin
            meta_r <= pins_in;
            pin_r  <= meta_r;
        end
    end

    wire txd_s   = pin_r[`ICT_PIN_TXD];
    wire sby_s   = pin_r[`ICT_PIN_SBY];
    wire hot_s   = pin_r[`ICT_PIN_HOT];
    wire cool_s  = pin_r[`ICT_PIN_COOL];
    wire hflt_s  = pin_r[`ICT_PIN_HFLT];
    wire lflt_s  = pin_r[`ICT_PIN_LFLT];
    wire short_s = pin_r[`ICT_PIN_SHORT];
    wire dhi_s   = pin_r[`ICT_PIN_DHI];
    wire dlo_s   = pin_r[`ICT_PIN_DLO];

    ////////////////////////////////////////////////////////////////////////////
    // Thermal state
    ict_pkg::ict_therm_t therm_r;
    ict_pkg::ict_therm_t therm_nxt;

    always_comb
    begin
        therm_nxt = therm_r;
        unique case (therm_r)
            ict_pkg::TH_RUN:  if (hot_s) therm_nxt = ict_pkg::TH_SHUT;
            ict_pkg::TH_SHUT: if (cool_s && !hot_s) therm_nxt = ict_pkg::TH_RUN;
        endcase
    end

    wire shut = (therm_r == ict_pkg::TH_SHUT);

    ////////////////////////////////////////////////////////////////////////////
    // Dominant timeout
    logic txd_prev_r;
    logic dom_fault_r;
    logic expired;

    wire txd_rise = txd_s && !txd_prev_r;

    ict_dom_timer #(
        .DOM_TIMEOUT_CYC (DOM_TIMEOUT_CYC)
    ) u_timer (
        .clk        (clk),
        .rst        (rst),
        .txd_low    (!txd_s),
        .hold_clear (sby_s || shut),
        .expired    (expired)
    );

    // set wins, cleared only by rising edge
    wire dom_fault_nxt = expired || (dom_fault_r && !txd_rise);

    ////////////////////////////////////////////////////////////////////////////
    // Driver and receiver decode
    // driver enable
    wire tx_en = !sby_s && !shut && !dom_fault_r && !expired;
    wire dom_nxt = tx_en && !txd_s;
    wire h_oe_nxt = !shut && !hflt_s;
    wire l_oe_nxt = !shut && !lflt_s;
    wire limit_nxt = dom_nxt && short_s;
    // Hysteresis band holds last value; upper threshold wins on overlap
    // thresholds, forced high on faults
    wire force_hi = shut || dom_fault_r || expired;
    wire rxd_nxt  = force_hi ? 1'h1 : dhi_s ? 1'h0 : dlo_s ? 1'h1 : rxd;

    ////////////////////////////////////////////////////////////////////////////
    // Output registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            therm_r        <= ict_pkg::TH_RUN;
            txd_prev_r     <= 1'h1;
            dom_fault_r    <= 1'h0;
            rxd            <= 1'h1;
            canh_dom       <= 1'h0;
            canl_dom       <= 1'h0;
            canh_oe        <= 1'h0;
            canl_oe        <= 1'h0;
            drive_limit    <= 1'h0;
            standby_active <= 1'h0;
            thermal_off    <= 1'h0;
            dom_fault      <= 1'h0;
        end
        else
        begin
            therm_r        <= therm_nxt;
            txd_prev_r     <= txd_s;
            dom_fault_r    <= dom_fault_nxt;
            rxd            <= rxd_nxt;
            canh_dom       <= dom_nxt;
            canl_dom       <= dom_nxt;
            canh_oe        <= h_oe_nxt;
            canl_oe        <= l_oe_nxt;
            drive_limit    <= limit_nxt;
            standby_active <= sby_s && !shut;
            thermal_off    <= therm_nxt == ict_pkg::TH_SHUT;
            dom_fault      <= dom_fault_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_timeout_hit;
        expired && !txd_rise;
    endsequence
    sequence s_released;
        dom_fault_r && !canh_dom && !canl_dom && rxd;
    endsequence

    a_standby_drive_off: assert property (sby_s |=> !canh_dom && !canl_dom)
        else $error("driver active in standby");
    a_dominant_drive: assert property (tx_en && !txd_s |=> canh_dom && canl_dom)
        else $error("dominant not driven");
    a_recessive_idle: assert property (txd_s |=> !canh_dom && !canl_dom)
        else $error("dominant on high transmit data");
    a_timeout_release: assert property (s_timeout_hit |=> s_released)
        else $error("timeout did not release bus");
    a_fault_hold: assert property (dom_fault_r && !txd_rise |=> dom_fault_r && !canh_dom)
        else $error("timeout fault dropped early");
    a_fault_clear: assert property (dom_fault_r && txd_rise && !expired |=> !dom_fault_r)
        else $error("rising edge did not clear fault");
    a_rx_low_thresh: assert property (!force_hi && dhi_s |=> !rxd)
        else $error("receive not low above threshold");
    a_rx_high_idle: assert property (!dhi_s && dlo_s ##1 !dhi_s && dlo_s |-> rxd)
        else $error("receive not high on idle bus");
    a_line_hiz: assert property ((hflt_s |=> !canh_oe) and (lflt_s |=> !canl_oe))
        else $error("faulted line still driven");
    a_thermal_float: assert property (shut |=> !canh_oe && !canl_oe && !canh_dom && rxd)
        else $error("outputs active in shutdown");
    a_thermal_stay: assert property (shut && !cool_s |=> $stable(therm_r))
        else $error("left shutdown before cooling");
    a_short_limit: assert property ((dom_nxt && short_s |=> drive_limit)
                                    and (!short_s |=> !drive_limit))
        else $error("drive limit wrong");

endmodule
`default_nettype wire

// [rtl/ict_dom_timer.sv]
// Dominant timeout timer for the transmit path
`timescale 1ns/1ps
`default_nettype none
`include "ict_params.svh"

module ict_dom_timer #(
    parameter int DOM_TIMEOUT_CYC = `ICT_DOM_TIMEOUT_CYC
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic txd_low,
    input  wire logic hold_clear,
    output logic      expired
);

    logic [`ICT_CNT_W-1:0] count_r;
    logic [`ICT_CNT_W-1:0] count_nxt;
    logic [`ICT_CNT_W-1:0] limit;
    logic                  at_limit;

    assign limit    = DOM_TIMEOUT_CYC[`ICT_CNT_W-1:0];
    assign at_limit = (count_r >= limit);
    // Only while data is low, so the rising edge is free to clear the fault
    assign expired  = at_limit && txd_low && !hold_clear;

    assign count_nxt = (hold_clear || !txd_low) ? `ICT_CNT_ZERO :
                       at_limit ? count_r : count_r + `ICT_CNT_ONE;

    always_ff @(posedge clk)
    begin
        if (rst)
            count_r <= `ICT_CNT_ZERO;
        else
            count_r <= count_nxt;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_timer_cleared: assert property ((hold_clear || !txd_low) |=> count_r == `ICT_CNT_ZERO)
        else $error("timer not cleared");
    a_timer_counts: assert property (txd_low && !hold_clear && !at_limit
                                     |=> count_r == $past(count_r) + `ICT_CNT_ONE)
        else $error("timer not counting");

endmodule
`default_nettype wire

// [rtl/ict_params.svh]
// Constants for the isolated CAN transceiver control block
`ifndef ICT_PARAMS_SVH
`define ICT_PARAMS_SVH

`define ICT_CLK_PERIOD_NS   25
`define ICT_DOM_TIMEOUT_NS  1200000
`define ICT_DOM_TIMEOUT_CYC ((`ICT_DOM_TIMEOUT_NS + `ICT_CLK_PERIOD_NS - 1) / `ICT_CLK_PERIOD_NS)

`define ICT_NPINS           9
`define ICT_PIN_TXD         0
`define ICT_PIN_SBY         1
`define ICT_PIN_HOT         2
`define ICT_PIN_COOL        3
`define ICT_PIN_HFLT        4
`define ICT_PIN_LFLT        5
`define ICT_PIN_SHORT       6
`define ICT_PIN_DHI         7
`define ICT_PIN_DLO         8
`define ICT_PIN_IDLE        9'h001

`define ICT_CNT_W           32
`define ICT_CNT_ZERO        32'h0000_0000
`define ICT_CNT_ONE         32'h0000_0001

`endif

// [rtl/ict_pkg.sv]
// Types for the isolated CAN transceiver control block
package ict_pkg;
    typedef enum logic {TH_RUN, TH_SHUT} ict_therm_t;
endpackage

// [testbench/ict_can_ctl_model.sv]
// Behavioural CAN protocol controller facing the transceiver logic side
`timescale 1ns/1ps
`default_nettype none
module ict_can_ctl_model (
    input  wire logic clk,
    input  wire logic rxd,
    output var logic  txd
);
    initial txd = 1'h1;
    // bounded dominant runs
    // Callers keep runs short except the stuck-controller case and the 30-cycle standby and thermal runs, which hold low past the timeout
    task automatic set_txd(input logic lv);
        txd = lv;
    endtask
    task automatic run(input logic lv, input int n);
        txd = lv;
        repeat (n) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the CAN transceiver control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int TO = 20;
    logic       clk, rst, sby, hot, cool, hf, lf, shrt, dhi, dlo;
    logic       rxd, ch, cl, hoe, loe, lim, sba, thr, flt;
    wire logic  txd;
    int         err_count = 0;
    int         n_tests = 0;
    wire logic [8:0] outs = {rxd, ch, cl, hoe, loe, lim, sba, thr, flt};

    ict_ctrl #(.DOM_TIMEOUT_CYC(TO)) uut (.clk(clk), .rst(rst), .txd(txd),
        .standby_select(sby), .temp_over_hot(hot), .temp_below_hyst(cool),
        .canh_fault(hf), .canl_fault(lf), .drv_short(shrt), .diff_above_hi(dhi),
        .diff_below_lo(dlo), .rxd(rxd), .canh_dom(ch), .canl_dom(cl), .canh_oe(hoe),
        .canl_oe(loe), .drive_limit(lim), .standby_active(sba), .thermal_off(thr),
        .dom_fault(flt));
    ict_can_ctl_model ctl (.clk(clk), .rxd(rxd), .txd(txd));

    ////////////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic conclude;
        if (err_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [8:0] exp);
        n_tests++;
        if (outs !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, outs, exp);
        end
    endtask
    task automatic chk_n(input int got, input int lo, input int hi);
        n_tests++;
        if (got < lo || got > hi)
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_timeout;
        int n;
        n = 0;
        dhi = 1'h1;
        dlo = 1'h0;
        ctl.run(1'h0, 4);
        chk(9'h0f0);
        // Bounded so a missing timeout cannot hang the run
        while (flt !== 1'h1 && n < 60)
        begin
            step(1);
            n++;
        end
        if (n == 60)
        begin
            err_count++;
            conclude;
        end
        chk(9'h131);
        chk_n(n, TO - 2, TO + 2);
        step(10);
        chk(9'h131);
        ctl.run(1'h1, 4);
        chk(9'h030);
        dhi = 1'h0;
        dlo = 1'h1;
        ctl.run(1'h0, 4);
        chk(9'h1f0);
        ctl.run(1'h1, 4);
    endtask
    task automatic t_restart;
        ctl.run(1'h0, 15);
        ctl.run(1'h1, 2);
        ctl.run(1'h0, 15);
        chk(9'h1f0);
        ctl.run(1'h1, 4);
        chk(9'h130);
    endtask
    task automatic t_standby;
        sby = 1'h1;
        ctl.run(1'h0, 30);
        chk(9'h134);
        ctl.run(1'h1, 4);
        sby = 1'h0;
        step(4);
        chk(9'h130);
    endtask
    task automatic t_thermal;
        hot = 1'h1;
        cool = 1'h0;
        dhi = 1'h1;
        dlo = 1'h0;
        ctl.run(1'h0, 30);
        chk(9'h102);
        ctl.set_txd(1'h1);
        hot = 1'h0;
        step(4);
        chk(9'h102);
        cool = 1'h1;
        dhi = 1'h0;
        dlo = 1'h1;
        step(4);
        chk(9'h130);
    endtask
    task automatic t_faults;
        shrt = 1'h1;
        ctl.run(1'h0, 4);
        chk(9'h1f8);
        shrt = 1'h0;
        step(4);
        chk(9'h1f0);
        ctl.run(1'h1, 1);
        hf = 1'h1;
        step(4);
        chk(9'h110);
        hf = 1'h0;
        lf = 1'h1;
        step(4);
        chk(9'h120);
        lf = 1'h0;
        step(4);
    endtask
    task automatic t_receiver;
        logic [1:0] pat [5] = '{2'h2, 2'h0, 2'h1, 2'h3, 2'h1};
        logic [8:0] exp [5] = '{9'h030, 9'h030, 9'h130, 9'h030, 9'h130};
        for (int i = 0; i < 5; i++)
        begin
            {dhi, dlo} = pat[i];
            step(4);
            chk(exp[i]);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        rst = 1'h1;
        sby = 1'h0;
        hot = 1'h0;
        cool = 1'h1;
        hf = 1'h0;
        lf = 1'h0;
        shrt = 1'h0;
        dhi = 1'h0;
        dlo = 1'h1;
        step(2);
        chk(9'h100);
        rst = 1'h0;
        step(4);
        chk(9'h130);
        t_timeout();
        t_restart();
        t_standby();
        t_thermal();
        t_faults();
        t_receiver();
        conclude();
    end
endmodule
`default_nettype wire
